// [src/pagc_pkg.sv]
// constants, field layout and carrier types for the clock generator
// assumes one 25 MHz clock; all derived clocks are one-cycle tick enables
package pagc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int PERIOD_W = 16;
	localparam int ACC_W = 26;
	localparam int DIV_W = 9;
	localparam int FACTOR_W = 10;

	localparam logic [3:0] CLOCK_DIVISOR_REGISTER_OFF = 4'h0;
	localparam logic [3:0] FEEDBACK_DIVISOR_REGISTER_OFF = 4'h1;
	localparam logic [3:0] AUX_CLOCK_CONTROL_OFF = 4'h2;

	localparam int PRESCALE_LSB = 0;
	localparam int PRESCALE_W = 5;
	localparam int POSTSCALE_LSB = 6;
	localparam int POSTSCALE_W = 2;
	localparam int FEEDBACK_LSB = 0;
	localparam int FEEDBACK_W = 9;
	localparam int AUX_ON_BIT = 15;
	localparam int AUX_LOCKED_BIT = 14;
	localparam int AUX_SRC_SEL_BIT = 13;
	localparam int AUX_DIV_LSB = 8;
	localparam int AUX_DIV_W = 3;
	localparam int AUX_REF_PRI_BIT = 7;
	localparam int AUX_REF_RC_BIT = 6;

	localparam logic [4:0] PRESCALE_RST = 5'h00;
	localparam logic [1:0] POSTSCALE_RST = 2'h1;
	localparam logic [8:0] FEEDBACK_RST = 9'h030;
	localparam logic AUX_ON_RST = 1'b0;
	localparam logic AUX_SRC_SEL_RST = 1'b1;
	localparam logic [2:0] AUX_DIV_RST = 3'h7;
	localparam logic AUX_REF_PRI_RST = 1'b0;
	localparam logic AUX_REF_RC_RST = 1'b0;

	localparam logic [8:0] PRESCALE_BASE = 9'h002;
	localparam logic [9:0] FEEDBACK_BASE = 10'h002;
	localparam logic [9:0] AUX_MULT = 10'h010;
	localparam logic [8:0] FCY_DIV = 9'h002;
	localparam logic [3:0] LOCK_MATCHES = 4'h4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pagc_bus_req_t;

	typedef struct packed {
		logic vco;
		logic fosc;
		logic fcy;
		logic aux_vco;
		logic aux;
	} pagc_ticks_t;

endpackage

// [src/pagc_mult_loop.sv]
// frequency multiplier model: measures the reference tick period and emits
// factor_in ticks per reference period; assumes ticks come from clk_in logic
`timescale 1ns/10ps
module pagc_mult_loop
	import pagc_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic enable_in,
	input wire logic ref_tick_in,
	input wire logic [FACTOR_W-1:0] factor_in,
	output logic out_tick_out,
	output logic locked_out
);

	logic [PERIOD_W-1:0] cnt_q;
	logic [PERIOD_W-1:0] period_q;
	logic [3:0] match_q;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic [ACC_W-1:0] sum;
	logic tick_d;
	logic close;

	// one count of jitter tolerated from the three-stage input sampling
	assign close = (cnt_q == period_q) || (cnt_q == period_q + 16'h0001) ||
		(cnt_q + 16'h0001 == period_q);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= 16'h0000;
			period_q <= 16'h0000;
		end else if (!enable_in) begin
			cnt_q <= 16'h0000;
			period_q <= 16'h0000;
		end else if (ref_tick_in) begin
			cnt_q <= 16'h0001;
			period_q <= cnt_q;
		end else if (cnt_q != 16'hFFFF) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// lost reference (counter stuck at top) drops lock
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			match_q <= 4'h0;
		end else if (!enable_in || cnt_q == 16'hFFFF) begin
			match_q <= 4'h0;
		end else if (ref_tick_in) begin
			if (period_q != 16'h0000 && close) begin
				if (match_q != LOCK_MATCHES) begin
					match_q <= match_q + 4'h1;
				end
			end else begin
				match_q <= 4'h0;
			end
		end
	end

	always_comb begin
		sum = acc_q + {16'h0000, factor_in};
		tick_d = 1'b0;
		acc_d = sum;
		if (period_q == 16'h0000) begin
			acc_d = '0;
		end else if (sum >= {10'h000, period_q}) begin
			tick_d = 1'b1;
			acc_d = sum - {10'h000, period_q};
			// output saturates at one tick per cycle; keep the phase bounded
			if (acc_d >= {10'h000, period_q}) begin
				acc_d = {10'h000, period_q};
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			acc_q <= '0;
			out_tick_out <= 1'b0;
		end else if (!enable_in) begin
			acc_q <= '0;
			out_tick_out <= 1'b0;
		end else begin
			acc_q <= acc_d;
			out_tick_out <= tick_d;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			locked_out <= 1'b0;
		end else begin
			locked_out <= enable_in && (match_q == LOCK_MATCHES);
		end
	end

endmodule

// [src/pagc_top.sv]
// main and auxiliary clock generation with its control registers
// assumes oscillator pins are slow against clk_in; derived clocks are tick enables
//
// How it works
// - input divided by prescale code plus two, range two to thirty-three
// - loop multiplies by feedback code plus two, so 0x1E gives 32
// - loop output divided by two, four or eight; code 00 is two
// - system clock is input times feedback over prescale times postscale
// - instruction clock is half the system clock
// - aux loop fed from primary or internal RC, always times sixteen
// - fine PWM resolution only when aux clock comes from aux loop
// - aux control bit 15 enables the aux loop, resets to zero
// - bit 14 is read-only aux lock status, resets to zero
// - bit 13 picks aux divider source: one aux loop, zero main loop
// - bits 10 to 8 set aux output divider, 111 is one, resets 111
// - bit 7 selects primary oscillator as aux reference, bit 6 internal RC which overrides it, neither gives none
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module pagc_top
	import pagc_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire pagc_bus_req_t bus_req_in,
	output logic [DATA_W-1:0] rdata_out,
	input wire logic primary_osc_in,
	input wire logic internal_rc_in,
	input wire logic main_use_rc_in,
	output pagc_ticks_t ticks_out,
	output logic main_locked_out,
	output logic aux_fine_resolution_out
);

	localparam int NPIN = 2;
	localparam int PIN_PRI = 0;
	localparam int PIN_RC = 1;
	localparam int NDIV = 4;
	localparam int DIV_PRE = 0;
	localparam int DIV_POST = 1;
	localparam int DIV_FCY = 2;
	localparam int DIV_AUX = 3;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] off);
		reg_hit = (addr == off);
	endfunction

	function automatic logic [DIV_W-1:0] postscale_div(input logic [1:0] code);
		case (code)
			2'h0: postscale_div = 9'h002;
			2'h1: postscale_div = 9'h004;
			default: postscale_div = 9'h008;
		endcase
	endfunction

	function automatic logic [DIV_W-1:0] aux_div(input logic [2:0] code);
		case (code)
			3'h7: aux_div = 9'h001;
			3'h6: aux_div = 9'h002;
			3'h5: aux_div = 9'h004;
			3'h4: aux_div = 9'h008;
			3'h3: aux_div = 9'h010;
			3'h2: aux_div = 9'h020;
			3'h1: aux_div = 9'h040;
			default: aux_div = 9'h100;
		endcase
	endfunction

	// control fields
	logic [PRESCALE_W-1:0] pll_input_prescale_q;
	logic [POSTSCALE_W-1:0] pll_output_postscale_q;
	logic [FEEDBACK_W-1:0] pll_feedback_factor_q;
	logic aux_pll_on_q;
	logic aux_divider_source_sel_q;
	logic [AUX_DIV_W-1:0] aux_output_divider_q;
	logic aux_ref_primary_sel_q;
	logic aux_ref_internal_rc_sel_q;

	logic wr_clock_divisor_register;
	logic wr_fbd;
	logic wr_aux;

	// pin sampling
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1_q;
	logic [NPIN-1:0] sync2_q;
	logic [NPIN-1:0] sync3_q;
	logic [NPIN-1:0] level_q;
	logic [NPIN-1:0] edge_q;

	// dividers
	logic [DIV_W-1:0] div_lim [NDIV];
	logic [NDIV-1:0] div_in;
	logic [NDIV-1:0] div_out;

	logic main_src_edge;
	logic main_vco_tick;
	logic main_locked;
	logic aux_ref_edge;
	logic aux_ref_present;
	logic aux_loop_en;
	logic aux_vco_tick;
	logic aux_locked;
	logic [FACTOR_W-1:0] main_factor;
	logic [DATA_W-1:0] clock_divisor_register_rd;
	logic [DATA_W-1:0] fbd_rd;
	logic [DATA_W-1:0] aux_rd;
	logic [DATA_W-1:0] rdata_d;

	assign wr_clock_divisor_register = bus_req_in.wr && reg_hit(bus_req_in.addr, CLOCK_DIVISOR_REGISTER_OFF);
	assign wr_fbd = bus_req_in.wr && reg_hit(bus_req_in.addr, FEEDBACK_DIVISOR_REGISTER_OFF);
	assign wr_aux = bus_req_in.wr && reg_hit(bus_req_in.addr, AUX_CLOCK_CONTROL_OFF);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pll_input_prescale_q <= PRESCALE_RST;
			pll_output_postscale_q <= POSTSCALE_RST;
		end else if (wr_clock_divisor_register) begin
			pll_input_prescale_q <= bus_req_in.wdata[PRESCALE_LSB +: PRESCALE_W];
			pll_output_postscale_q <= bus_req_in.wdata[POSTSCALE_LSB +: POSTSCALE_W];
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pll_feedback_factor_q <= FEEDBACK_RST;
		end else if (wr_fbd) begin
			pll_feedback_factor_q <= bus_req_in.wdata[FEEDBACK_LSB +: FEEDBACK_W];
		end
	end

	// lock bit is not a storage bit, so a write to it has nowhere to land
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			aux_pll_on_q <= AUX_ON_RST;
			aux_divider_source_sel_q <= AUX_SRC_SEL_RST;
			aux_output_divider_q <= AUX_DIV_RST;
			aux_ref_primary_sel_q <= AUX_REF_PRI_RST;
			aux_ref_internal_rc_sel_q <= AUX_REF_RC_RST;
		end else if (wr_aux) begin
			aux_pll_on_q <= bus_req_in.wdata[AUX_ON_BIT];
			aux_divider_source_sel_q <= bus_req_in.wdata[AUX_SRC_SEL_BIT];
			aux_output_divider_q <= bus_req_in.wdata[AUX_DIV_LSB +: AUX_DIV_W];
			aux_ref_primary_sel_q <= bus_req_in.wdata[AUX_REF_PRI_BIT];
			aux_ref_internal_rc_sel_q <= bus_req_in.wdata[AUX_REF_RC_BIT];
		end
	end

	// three-stage sampling; first stage feeds only the second
	assign pin_raw[PIN_PRI] = primary_osc_in;
	assign pin_raw[PIN_RC] = internal_rc_in;

	generate
		for (genvar p = 0; p < NPIN; p++) begin : g_pin
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					sync1_q[p] <= 1'b0;
					sync2_q[p] <= 1'b0;
					sync3_q[p] <= 1'b0;
				end else begin
					sync1_q[p] <= pin_raw[p];
					sync2_q[p] <= sync1_q[p];
					sync3_q[p] <= sync2_q[p];
				end
			end

			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					level_q[p] <= 1'b0;
					edge_q[p] <= 1'b0;
				end else begin
					edge_q[p] <= 1'b0;
					if (sync2_q[p] == sync3_q[p]) begin
						level_q[p] <= sync3_q[p];
						edge_q[p] <= sync3_q[p] && !level_q[p];
					end
				end
			end
		end
	endgenerate

	// main path
	assign main_src_edge = main_use_rc_in ? edge_q[PIN_RC] : edge_q[PIN_PRI];
	assign main_factor = {1'b0, pll_feedback_factor_q} + FEEDBACK_BASE;

	assign div_in[DIV_PRE] = main_src_edge;
	assign div_lim[DIV_PRE] = {4'h0, pll_input_prescale_q} + PRESCALE_BASE;

	pagc_mult_loop u_main_loop (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.enable_in(1'b1),
		.ref_tick_in(div_out[DIV_PRE]),
		.factor_in(main_factor),
		.out_tick_out(main_vco_tick),
		.locked_out(main_locked)
	);

	// system clock = input * M / (N1 * N2), instruction clock one half of it
	assign div_in[DIV_POST] = main_vco_tick;
	assign div_lim[DIV_POST] = postscale_div(pll_output_postscale_q);
	assign div_in[DIV_FCY] = div_out[DIV_POST];
	assign div_lim[DIV_FCY] = FCY_DIV;

	// aux path: internal RC overrides, else primary when selected, else nothing
	always_comb begin
		aux_ref_edge = 1'b0;
		aux_ref_present = 1'b0;
		if (aux_ref_internal_rc_sel_q) begin
			aux_ref_edge = edge_q[PIN_RC];
			aux_ref_present = 1'b1;
		end else if (aux_ref_primary_sel_q) begin
			aux_ref_edge = edge_q[PIN_PRI];
			aux_ref_present = 1'b1;
		end
	end

	assign aux_loop_en = aux_pll_on_q;

	pagc_mult_loop u_aux_loop (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.enable_in(aux_loop_en),
		.ref_tick_in(aux_ref_edge),
		.factor_in(AUX_MULT),
		.out_tick_out(aux_vco_tick),
		.locked_out(aux_locked)
	);

	assign div_in[DIV_AUX] = aux_divider_source_sel_q ? aux_vco_tick : main_vco_tick;
	assign div_lim[DIV_AUX] = aux_div(aux_output_divider_q);

	// writes that shrink a limit below the count wrap on the next input tick
	generate
		for (genvar d = 0; d < NDIV; d++) begin : g_div
			logic [DIV_W-1:0] cnt_q;
			logic out_q;

			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					cnt_q <= '0;
					out_q <= 1'b0;
				end else begin
					out_q <= 1'b0;
					if (div_in[d]) begin
						if (cnt_q + 9'h001 >= div_lim[d]) begin
							cnt_q <= '0;
							out_q <= 1'b1;
						end else begin
							cnt_q <= cnt_q + 9'h001;
						end
					end
				end
			end

			assign div_out[d] = out_q;
		end
	endgenerate

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ticks_out <= '0;
		end else begin
			ticks_out.vco <= main_vco_tick;
			ticks_out.fosc <= div_out[DIV_POST];
			ticks_out.fcy <= div_out[DIV_FCY];
			ticks_out.aux_vco <= aux_vco_tick;
			ticks_out.aux <= div_out[DIV_AUX];
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			main_locked_out <= 1'b0;
		end else begin
			main_locked_out <= main_locked;
		end
	end

	// fine steps need the sixteen-times loop itself on the aux path
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			aux_fine_resolution_out <= 1'b0;
		end else begin
			aux_fine_resolution_out <= aux_pll_on_q && aux_locked && aux_ref_present &&
				aux_divider_source_sel_q;
		end
	end

	// read images; unimplemented bits are tied low
	assign clock_divisor_register_rd = {8'h00, pll_output_postscale_q, 1'b0, pll_input_prescale_q};
	assign fbd_rd = {7'h00, pll_feedback_factor_q};
	assign aux_rd = {aux_pll_on_q, aux_pll_on_q && aux_locked,
		aux_divider_source_sel_q, 2'h0, aux_output_divider_q,
		aux_ref_primary_sel_q, aux_ref_internal_rc_sel_q, 6'h00};

	always_comb begin
		rdata_d = 16'h0000;
		if (reg_hit(bus_req_in.addr, CLOCK_DIVISOR_REGISTER_OFF)) begin
			rdata_d = clock_divisor_register_rd;
		end else if (reg_hit(bus_req_in.addr, FEEDBACK_DIVISOR_REGISTER_OFF)) begin
			rdata_d = fbd_rd;
		end else if (reg_hit(bus_req_in.addr, AUX_CLOCK_CONTROL_OFF)) begin
			rdata_d = aux_rd;
		end
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 16'h0000;
		end else if (bus_req_in.rd) begin
			rdata_out <= rdata_d;
		end else begin
			rdata_out <= 16'h0000;
		end
	end

endmodule

// [tb/pagc_monitor.sv]
// checker for the clock generator register port and tick outputs
// assumes it is bound to pagc_top and sees only its ports
`timescale 1ns/10ps
module pagc_monitor
	import pagc_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire pagc_bus_req_t bus_req_in,
	input wire logic [DATA_W-1:0] rdata_out,
	input wire logic primary_osc_in,
	input wire logic internal_rc_in,
	input wire logic main_use_rc_in,
	input wire pagc_ticks_t ticks_out,
	input wire logic main_locked_out,
	input wire logic aux_fine_resolution_out
);
	logic on_q;
	logic sel_q;
	logic seen_q;
	logic [3:0] fosc_cnt_q;
	logic aux_rd;
	assign aux_rd = bus_req_in.rd && bus_req_in.addr == AUX_CLOCK_CONTROL_OFF;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			on_q <= AUX_ON_RST;
			sel_q <= AUX_SRC_SEL_RST;
		end else if (bus_req_in.wr && bus_req_in.addr == AUX_CLOCK_CONTROL_OFF) begin
			on_q <= bus_req_in.wdata[AUX_ON_BIT];
			sel_q <= bus_req_in.wdata[AUX_SRC_SEL_BIT];
		end
	end
	// first window skipped, its phase is unknown
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fosc_cnt_q <= 4'h0;
			seen_q <= 1'b0;
		end else if (ticks_out.fcy) begin
			fosc_cnt_q <= 4'h0;
			seen_q <= 1'b1;
		end else if (ticks_out.fosc && fosc_cnt_q != 4'hF) begin
			fosc_cnt_q <= fosc_cnt_q + 4'h1;
		end
	end
	sequence aux_off_s;
		!on_q [*3];
	endsequence
	rdata_idle_a: assert property (!bus_req_in.rd |=> rdata_out == 16'h0000)
		else $error("read data not zero outside a read");
	unmapped_zero_a: assert property (bus_req_in.rd && bus_req_in.addr > 4'h2
		|=> rdata_out == 16'h0000) else $error("unmapped read not zero");
	aux_unused_zero_a: assert property (aux_rd |=> rdata_out[12:11] == 2'h0
		&& rdata_out[5:0] == 6'h00) else $error("unused aux bits not zero");
	lock_off_zero_a: assert property (aux_rd && !on_q |=>
		!rdata_out[AUX_LOCKED_BIT] && !rdata_out[AUX_ON_BIT]) else $error("lock set while off");
	fcy_half_a: assert property (ticks_out.fcy && seen_q |->
		fosc_cnt_q + {3'h0, ticks_out.fosc} == 4'h2) else $error("fcy not half of fosc");
	fosc_gap_a: assert property (ticks_out.fosc |=> !ticks_out.fosc)
		else $error("fosc ticks adjacent");
	aux_quiet_a: assert property (aux_off_s |-> !ticks_out.aux_vco)
		else $error("aux loop ticks while off");
	fine_src_a: assert property (aux_fine_resolution_out |-> $past(on_q) && $past(sel_q))
		else $error("fine resolution without aux loop");
endmodule

// [tb/pagc_top_tb.sv]
// self-checking bench for pagc_top over its register port and tick outputs
// assumes the monitor file is compiled before this one
`timescale 1ns/10ps
`define CHK(g, e) chk_v((g), (e))
module pagc_top_tb
	import pagc_pkg::*;
;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	pagc_bus_req_t bus_q = '0;
	logic [DATA_W-1:0] rdata_out;
	logic primary_osc_in = 1'b0;
	logic internal_rc_in = 1'b0;
	logic main_use_rc_in = 1'b0;
	pagc_ticks_t ticks_out;
	logic main_locked_out;
	logic aux_fine_resolution_out;
	int fails = 0;
	int checks_done = 0;
	int pc = 0;
	int p;
	always #20 clk_in = !clk_in;
	// slow pins keep every loop below one tick per clock
	always @(posedge clk_in) begin
		pc++;
		if (pc % 20 == 0) primary_osc_in <= !primary_osc_in;
		if (pc % 10 == 0) internal_rc_in <= !internal_rc_in;
	end
	pagc_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_req_in(bus_q), .rdata_out(rdata_out),
		.primary_osc_in(primary_osc_in), .internal_rc_in(internal_rc_in),
		.main_use_rc_in(main_use_rc_in), .ticks_out(ticks_out),
		.main_locked_out(main_locked_out), .aux_fine_resolution_out(aux_fine_resolution_out));
	task automatic conclude();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic near(input int c, input int e);
		return (c >= e - 2) && (c <= e + 2);
	endfunction
	// strobe left up so a read may follow with no gap
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_in);
		bus_q <= '0;
		#1;
		`CHK(rdata_out, e);
		@(posedge clk_in);
	endtask
	task automatic settle(input logic aux);
		int i;
		repeat (1500) @(posedge clk_in);
		for (i = 0; i < 4000 && (main_locked_out !== 1'b1
			|| (aux && aux_fine_resolution_out !== 1'b1)); i++) @(posedge clk_in);
		if (i == 4000) begin
			fails++;
			conclude();
		end
	endtask
	task automatic measure(input int ev, input int ef, input int ey, input int eav, input int ea);
		int c[5];
		c = '{default: 0};
		repeat (1200) begin
			@(negedge clk_in);
			c[0] += ticks_out.vco;
			c[1] += ticks_out.fosc;
			c[2] += ticks_out.fcy;
			c[3] += ticks_out.aux_vco;
			c[4] += ticks_out.aux;
		end
		`CHK(near(c[0], ev), 1'b1);
		`CHK(near(c[1], ef), 1'b1);
		`CHK(near(c[2], ey), 1'b1);
		`CHK(near(c[3], eav), 1'b1);
		`CHK(near(c[4], ea), 1'b1);
	endtask
	task automatic run_cfg(input logic [15:0] aux, input logic rc, input logic [15:0] erd,
		input int ev, input int eav, input int ea, input logic fine);
		main_use_rc_in <= rc;
		// loop off for one write so a stale lock from the last setup cannot show
		wr(4'h2, aux & 16'h7FFF);
		wr(4'h2, aux);
		rd(4'h2, aux & 16'hBFFF);
		settle(fine);
		rd(4'h2, erd);
		measure(ev, ev / 2, ev / 4, eav, ea);
		`CHK(aux_fine_resolution_out, fine);
		`CHK(main_locked_out, 1'b1);
		@(posedge clk_in);
	endtask
	initial begin
		repeat (10) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		rd(4'h0, 16'h0040);
		rd(4'h1, 16'h0030);
		rd(4'h2, 16'h2700);
		rd(4'h3, 16'h0000);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
		wr(4'h2, 16'hFFFF);
		rd(4'h2, 16'hA7C0);
		for (p = 0; p < 8; p++) begin
			wr(4'h2, {5'h00, p[2:0], 8'h00});
			rd(4'h2, {5'h00, p[2:0], 8'h00});
		end
		// prescale three, multiply sixteen: 160 loop ticks per window
		wr(4'h1, 16'h000E);
		wr(4'h2, 16'hA6C0);
		for (p = 0; p < 4; p++) begin
			wr(4'h0, {8'h00, p[1:0], 6'h01});
			rd(4'h0, {8'h00, p[1:0], 6'h01});
			settle(1'b1);
			measure(160, 160 / (p == 0 ? 2 : p == 1 ? 4 : 8), 80 / (p == 0 ? 2 : p == 1 ? 4 : 8),
				960, 480);
			// next request must start just after a rising edge
			@(posedge clk_in);
		end
		wr(4'h0, 16'h0001);
		run_cfg(16'hA680, 1'b0, 16'hE680, 160, 480, 240, 1'b1);
		run_cfg(16'h8780, 1'b0, 16'hC780, 160, 480, 160, 1'b0);
		run_cfg(16'h2780, 1'b0, 16'h2780, 160, 0, 0, 1'b0);
		run_cfg(16'hA700, 1'b0, 16'hA700, 160, 0, 0, 1'b0);
		run_cfg(16'hA6C0, 1'b1, 16'hE6C0, 320, 960, 480, 1'b1);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		`CHK(main_locked_out, 1'b0);
		`CHK(ticks_out, 5'h00);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		rd(4'h2, 16'h2700);
		rd(4'h0, 16'h0040);
		conclude();
	end
endmodule
bind pagc_top pagc_monitor mon (.clk_in(clk_in), .nrst_in(nrst_in), .bus_req_in(bus_req_in),
	.rdata_out(rdata_out), .primary_osc_in(primary_osc_in), .internal_rc_in(internal_rc_in),
	.main_use_rc_in(main_use_rc_in), .ticks_out(ticks_out), .main_locked_out(main_locked_out),
	.aux_fine_resolution_out(aux_fine_resolution_out));
